// *** inc/fault_dgram_pkg.sv ***
// Constants and types for the fault report datagram handler
package fault_dgram_pkg;
  localparam logic [7:0] SUBF_PULSE_TEST     = 8'h10;
  localparam logic [7:0] SUBF_PULSE_DONE     = 8'h11;
  localparam logic [7:0] SUBF_CLEAR_CIRCUIT  = 8'h12;
  localparam logic [7:0] SUBF_CLEAR_ALL      = 8'h13;
  localparam logic [7:0] SUBF_REPORT_FAULT   = 8'h0f;
  localparam logic [7:0] SUBF_SWITCH_BUS     = 8'h1c;
  localparam logic [7:0] BUS_POS_A           = 8'h00;
  localparam logic [7:0] BUS_POS_B           = 8'h01;
  localparam logic [3:0] FAULT_TYPE_SCANNER  = 4'h3;
  localparam logic [1:0] CLASS_DISC_OUT      = 2'h0;
  localparam logic [1:0] CLASS_DISC_IN       = 2'h1;
  localparam logic [1:0] CLASS_ANA_OUT       = 2'h2;
  localparam logic [1:0] CLASS_ANA_IN        = 2'h3;
  localparam logic [5:0] DIAG_INDEX_MAX      = 6'h3f;
  localparam logic [3:0] FAULT_REC_ONE       = 4'h1;
  localparam logic [2:0] REPORT_LAST_BYTE    = 3'h6;
  localparam logic [2:0] CHIP_LAST_BYTE      = 3'h2;
  localparam int         NUM_CIRCUITS        = 6;
  localparam logic [2:0] ANA_FIRST_OUTPUT    = 3'h4;
  localparam logic [2:0] LAST_CIRCUIT        = 3'h5;
  // Device flavours, selected by a strap input
  localparam logic [1:0] FLAVOUR_CHIP        = 2'h0;
  localparam logic [1:0] FLAVOUR_SCANNER     = 2'h1;
  localparam logic [1:0] FLAVOUR_IFACE       = 2'h2;
  localparam logic [7:0] ZERO_BYTE           = 8'h00;
  localparam logic [2:0] PULSE_CYCLES        = 3'h4;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_PULSE = 5'b00010,
    ST_DONE  = 5'b00100,
    ST_REPORT= 5'b01000,
    ST_GAP   = 5'b10000
  } ctl_state_t;
endpackage

// *** logic/report_builder.sv ***
// Fault report payload byte selector for the three device flavours
`timescale 1ns/1ps
`default_nettype none
module report_builder
  import fault_dgram_pkg::*;
(
  input  wire logic [1:0]  flavour,
  input  wire logic [2:0]  byte_index,
  input  wire logic [1:0]  module_class,
  input  wire logic        long_fault,
  input  wire logic        suppress_alarm,
  input  wire logic [5:0]  diag_index,
  input  wire logic [15:0] ref_offset,
  input  wire logic [15:0] ctl_word,
  output logic      [7:0]  payload
);
  always_comb begin
    payload = ZERO_BYTE;
    if (flavour == FLAVOUR_CHIP) begin
      if (byte_index == 3'h1) begin
        payload = {2'h0, diag_index};                                   // R1
      end
    end else begin
      case (byte_index)
        3'h0: payload = {FAULT_TYPE_SCANNER, module_class,
                         long_fault, suppress_alarm & ~long_fault};       // R2 R3
        3'h1: payload = (flavour == FLAVOUR_SCANNER) ?
                        {2'h0, diag_index} : ZERO_BYTE;                  // R4 R7
        3'h2: payload = {FAULT_REC_ONE, FAULT_REC_ONE};                  // R5
        3'h3: payload = ref_offset[7:0];                                 // R6 R7
        3'h4: payload = ref_offset[15:8];                                // R6 R7
        3'h5: payload = ctl_word[7:0];
        3'h6: payload = ctl_word[15:8];
        default: payload = ZERO_BYTE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** logic/circuit_faults.sv ***
// Per-circuit sticky fault flags with clear and re-report detection
`timescale 1ns/1ps
`default_nettype none
module circuit_faults
  import fault_dgram_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_sync_n,
  input  wire logic [NUM_CIRCUITS-1:0] fault_cond,
  input  wire logic [NUM_CIRCUITS-1:0] clear_mask,
  input  wire logic                    test_strobe,
  output logic      [NUM_CIRCUITS-1:0] latched,
  output logic      [NUM_CIRCUITS-1:0] new_fault
);
  genvar i;
  generate
    for (i = 0; i < NUM_CIRCUITS; i++) begin : g_circ
      // A fault that is still present while cleared sets again: set wins
      always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          latched[i] <= 1'b0;
        end else if (fault_cond[i]) begin
          latched[i] <= 1'b1;                                              // R12
        end else if (clear_mask[i]) begin
          latched[i] <= 1'b0;
        end
      end
      // Pulse test samples the condition too, so its faults report normally
      assign new_fault[i] = fault_cond[i] & (~latched[i] | clear_mask[i]
                                             | test_strobe);               // R10
    end
  endgenerate
endmodule
`default_nettype wire

// *** logic/fault_report_datagram_handler.sv ***
// Datagram handler: pulse test, fault clears, bus switch, fault reports
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Chip device byte 1 is diag byte index
// R2 - Seven byte report, type 0011, class field
// R3 - Byte 0 carries long flag and suppress bit
// R4 - Scanner byte 1 is diag table index
// R5 - Byte 2 record number and count are one
// R6 - Scanner bytes 3-4 hold internal offset
// R7 - Interface unit byte 1 zero, slot reference
// R8 - Foreign hosts ignore bytes 5 and 6
// R9 - Subfunction 10h pulses outputs unless overridden
// R10 - Test faults reported; release power diagnostics
// R11 - Send 11h to initiator after test
// R12 - 12h clears named circuit; persistent re-reports
// R13 - Analog block: 0-3 inputs, 4-5 outputs
// R14 - 13h clears all, retries memory write
// R15 - 1Ch selects bus A or B, else ignored
// R16 - Ignore switch while monitor forces position
// R17 - Controllers report loss and addition of block
// R18 - Read request address LSB first, length 128
// R19 - Legacy target top address byte is 80
// R20 - Memory read: type, zero, offset minus one
// R21 - Program register read: type 4, name, length
// R22 - Local register read: type 0, two names
// R23 - Unknown subfunctions are silently discarded
module fault_report_datagram_handler
  import fault_dgram_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rstn,
  input  wire logic [1:0]              flavour,
  input  wire logic                    rx_valid,
  input  wire logic [7:0]              rx_subfunc,
  input  wire logic [7:0]              rx_data0,
  input  wire logic [7:0]              rx_source,
  input  wire logic                    pulse_override,
  input  wire logic                    isolated_block,
  input  wire logic                    monitor_forced,
  input  wire logic [NUM_CIRCUITS-1:0] fault_cond,
  input  wire logic [1:0]              module_class,
  input  wire logic                    long_fault,
  input  wire logic                    suppress_alarm,
  input  wire logic [5:0]              diag_index,
  input  wire logic [15:0]             ref_offset,
  input  wire logic [15:0]             ctl_word,
  input  wire logic                    nvm_fault,
  input  wire logic                    nvm_write_ok,
  input  wire logic                    tx_ready,
  output logic                         tx_valid,
  output logic      [7:0]              tx_subfunc,
  output logic      [7:0]              tx_dest,
  output logic      [2:0]              tx_index,
  output logic      [7:0]              tx_byte,
  output logic                         tx_last,
  output logic      [NUM_CIRCUITS-1:0] pulse_drive,
  output logic                         power_diag_release,
  output logic                         nvm_rewrite,
  output logic                         bus_select_b,
  output logic      [NUM_CIRCUITS-1:0] fault_latched
);
  logic                    rst_meta;
  logic                    rst_sync_n;
  ctl_state_t              state;
  logic [2:0]              pulse_cnt;
  logic [7:0]              initiator;
  logic [NUM_CIRCUITS-1:0] clear_mask;
  logic [NUM_CIRCUITS-1:0] new_fault;
  logic [NUM_CIRCUITS-1:0] pending;
  logic                    nvm_pending;
  logic                    nvm_report;
  logic [7:0]              payload;
  logic [2:0]              last_byte;
  logic                    is_pulse;
  logic                    is_clear;
  logic                    is_clear_all;
  logic                    is_switch;
  logic                    test_strobe;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Decode; anything else falls through untouched
  assign is_pulse     = rx_valid && rx_subfunc == SUBF_PULSE_TEST;        // R23
  assign is_clear     = rx_valid && rx_subfunc == SUBF_CLEAR_CIRCUIT;
  assign is_clear_all = rx_valid && rx_subfunc == SUBF_CLEAR_ALL;
  assign is_switch    = rx_valid && rx_subfunc == SUBF_SWITCH_BUS;
  assign test_strobe  = state == ST_PULSE && pulse_cnt == PULSE_CYCLES;
  assign last_byte    = (flavour == FLAVOUR_CHIP) ? CHIP_LAST_BYTE : REPORT_LAST_BYTE;

  // Circuit 0-3 are analog inputs, 4-5 outputs; out of range clears nothing
  always_comb begin
    clear_mask = '0;
    if (is_clear_all) begin
      clear_mask = '1;                                                     // R14
    end else if (is_clear && rx_data0 <= {5'h0, LAST_CIRCUIT}) begin
      clear_mask[rx_data0[2:0]] = 1'b1;                                    // R12 R13
    end
  end

  circuit_faults u_faults (
    .clk_sys     (clk_sys),
    .rst_sync_n  (rst_sync_n),
    .fault_cond  (fault_cond),
    .clear_mask  (clear_mask),
    .test_strobe (test_strobe),
    .latched     (fault_latched),
    .new_fault   (new_fault)
  );

  report_builder u_build (
    .flavour        (flavour),
    .byte_index     (tx_index),
    .module_class   (module_class),
    .long_fault     (long_fault),
    .suppress_alarm (suppress_alarm),
    .diag_index     (diag_index),
    .ref_offset     (ref_offset),
    .ctl_word       (ctl_word),
    .payload        (payload)
  );

  // Pending reports: new events set, a sent report clears the lowest
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~((state == ST_REPORT && tx_ready && tx_last && !nvm_report)
                 ? (pending & (~pending + 1'b1)) : '0)) | new_fault;       // R10 R12
    end
  end

  // Memory fault retry on clear-all; failure regenerates its report
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      nvm_rewrite <= 1'b0;
      nvm_pending <= 1'b0;
    end else begin
      nvm_rewrite <= is_clear_all && nvm_fault;                            // R14
      if (nvm_rewrite && !nvm_write_ok) begin
        nvm_pending <= 1'b1;                                               // R14
      end else if (state == ST_REPORT && tx_ready && tx_last && nvm_report) begin
        nvm_pending <= 1'b0;
      end
    end
  end

  // Bus selection
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bus_select_b <= 1'b0;
    end else if (is_switch && !monitor_forced) begin                       // R16
      if (rx_data0 == BUS_POS_A) begin
        bus_select_b <= 1'b0;                                              // R15
      end else if (rx_data0 == BUS_POS_B) begin
        bus_select_b <= 1'b1;                                              // R15
      end
    end
  end

  // Sequencer for pulse test and outgoing datagrams
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state              <= ST_IDLE;
      pulse_cnt          <= '0;
      initiator          <= ZERO_BYTE;
      pulse_drive        <= '0;
      power_diag_release <= 1'b0;
      tx_valid           <= 1'b0;
      tx_subfunc         <= ZERO_BYTE;
      tx_dest            <= ZERO_BYTE;
      tx_index           <= '0;
      tx_last            <= 1'b0;
      nvm_report         <= 1'b0;
    end else begin
      power_diag_release <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (is_pulse && !pulse_override) begin                           // R9
            state              <= ST_PULSE;
            initiator          <= rx_source;
            pulse_cnt          <= '0;
            pulse_drive        <= '1;                                      // R9
            power_diag_release <= isolated_block;                          // R10
          end else if (pending != '0 || nvm_pending) begin
            state      <= ST_REPORT;
            nvm_report <= (pending == '0);
            tx_valid   <= 1'b1;
            tx_subfunc <= SUBF_REPORT_FAULT;
            tx_dest    <= ZERO_BYTE;
            tx_index   <= '0;
            tx_last    <= 1'b0;
          end
        end
        ST_PULSE: begin
          pulse_cnt <= pulse_cnt + 3'h1;
          if (test_strobe) begin
            pulse_drive <= '0;
            state       <= ST_DONE;
            tx_valid    <= 1'b1;
            tx_subfunc  <= SUBF_PULSE_DONE;                                // R11
            tx_dest     <= initiator;                                      // R11
            tx_index    <= '0;
            tx_last     <= 1'b1;
          end
        end
        ST_DONE: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            state    <= ST_GAP;
          end
        end
        ST_REPORT: begin
          if (tx_ready) begin
            if (tx_last) begin
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
              state    <= ST_GAP;
            end else begin
              tx_index <= tx_index + 3'h1;                                 // R2
              tx_last  <= (tx_index + 3'h1) == last_byte;
            end
          end
        end
        ST_GAP: begin
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Payload registered so the output comes from a flip-flop
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_byte <= ZERO_BYTE;
    end else begin
      tx_byte <= payload;
    end
  end

  chk_switch_forced_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (is_switch && monitor_forced) |=> $stable(bus_select_b))                // R16
    else $error("bus moved while forced");
  chk_switch_bad_value: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (is_switch && rx_data0 > BUS_POS_B) |=> $stable(bus_select_b))          // R15
    else $error("bus moved on bad position");
  chk_switch_to_b: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (is_switch && !monitor_forced && rx_data0 == BUS_POS_B) |=> bus_select_b) // R15
    else $error("bus B not selected");
  sequence s_test_start;
    state == ST_IDLE && is_pulse && !pulse_override;
  endsequence
  sequence s_test_done;
    tx_valid && tx_subfunc == SUBF_PULSE_DONE;
  endsequence
  chk_pulse_then_done: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    s_test_start |-> ##6 s_test_done)                                       // R11
    else $error("pulse done not sent in time");
  chk_override_blocks: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (state == ST_IDLE && is_pulse && pulse_override) |=> pulse_drive == '0)  // R9
    else $error("pulse test ran under override");
  chk_report_type: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (tx_subfunc == SUBF_REPORT_FAULT && tx_valid && tx_index == 3'h0
     && flavour != FLAVOUR_CHIP) |=> tx_byte[7:4] == FAULT_TYPE_SCANNER)    // R2
    else $error("wrong fault type nibble");
  chk_report_records: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (tx_subfunc == SUBF_REPORT_FAULT && tx_valid && tx_index == 3'h2
     && flavour != FLAVOUR_CHIP) |=> tx_byte == {FAULT_REC_ONE, FAULT_REC_ONE}) // R5
    else $error("record fields not one");
  chk_iface_byte1: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (tx_valid && tx_index == 3'h1 && flavour == FLAVOUR_IFACE) |=> tx_byte == ZERO_BYTE) // R7
    else $error("interface byte 1 not zero");
  chk_clear_all: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
    (is_clear_all && fault_cond == '0) |=> fault_latched == '0)             // R14
    else $error("clear all left a fault");
  chk_release_pulse: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R10
    (state == ST_IDLE && is_pulse && !pulse_override && isolated_block) |=> power_diag_release)
    else $error("power diagnostics not released");
  chk_rewrite_pulse: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R14
    (is_clear_all && nvm_fault) |=> nvm_rewrite)
    else $error("memory rewrite not started");
  chk_clear_output: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R13
    (is_clear && rx_data0 == {5'h0, ANA_FIRST_OUTPUT} && !fault_cond[ANA_FIRST_OUTPUT])
    |=> !fault_latched[ANA_FIRST_OUTPUT])
    else $error("output circuit not cleared");
  // Drive must cover the whole test window and drop with the done datagram
  sequence s_drive_window;
    (pulse_drive == '1) [*5] ##1 (pulse_drive == '0);
  endsequence
  chk_pulse_width: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R9
    s_test_start |=> s_drive_window)
    else $error("pulse drive window wrong");
  chk_pending_sent: assert property (@(posedge clk_sys) disable iff (!rst_sync_n) // R10 R12
    (state == ST_IDLE && pending != '0 && !(is_pulse && !pulse_override))
    |=> (tx_valid && tx_subfunc == SUBF_REPORT_FAULT))
    else $error("pending fault not reported");
endmodule
`default_nettype wire

// *** tb/ctl_model.sv ***
// Bus controller model that accepts datagrams sent by the node
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       slow,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_subfunc,
  input  wire logic [7:0] tx_dest,
  input  wire logic [2:0] tx_index,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] got [0:6];
  logic [7:0] got_sub;
  logic [7:0] got_dest;
  logic [2:0] last_idx;
  logic       lag;
  logic       hold;
  int         frames;
  int         ends;
  wire        acc = tx_valid && tx_ready;

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_ready <= 1'b0;
      lag      <= 1'b0;
      hold     <= 1'b0;
      frames   <= 0;
      ends     <= 0;
    end else begin
      // Slow mode stalls every other cycle so the node must hold its byte
      hold     <= slow && !hold;
      tx_ready <= slow ? hold : 1'b1;
      lag      <= acc;
      // Byte lane trails the index by one cycle; trailing bytes kept raw
      if (lag) begin
        got[last_idx] <= tx_byte;
      end
      if (acc) begin
        last_idx <= tx_index;
        if (tx_last) begin
          ends <= ends + 1;
        end
        if (tx_index == 3'h0) begin
          frames   <= frames + 1;
          got_sub  <= tx_subfunc;
          got_dest <= tx_dest;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking testbench for the fault report datagram handler
`timescale 1ns/1ps
`default_nettype none
module tb
  import fault_dgram_pkg::*;
;
  logic clk_sys, rstn, slow, rx_valid, pulse_override, isolated_block, monitor_forced;
  logic long_fault, suppress_alarm, nvm_fault, nvm_write_ok, tx_ready, tx_valid, tx_last;
  logic power_diag_release, nvm_rewrite, bus_select_b, rel_seen, nvm_seen;
  logic [1:0] flavour, module_class;
  logic [7:0] rx_subfunc, rx_data0, rx_source, tx_subfunc, tx_dest, tx_byte;
  logic [2:0] tx_index;
  logic [5:0] fault_cond, diag_index, pulse_drive, fault_latched;
  logic [15:0] ref_offset, ctl_word;
  int error_cnt, compares, pd_cnt, cyc;

  fault_report_datagram_handler u_dut (.clk_sys(clk_sys), .rstn(rstn), .flavour(flavour),
    .rx_valid(rx_valid), .rx_subfunc(rx_subfunc), .rx_data0(rx_data0), .rx_source(rx_source),
    .pulse_override(pulse_override), .isolated_block(isolated_block),
    .monitor_forced(monitor_forced), .fault_cond(fault_cond), .module_class(module_class),
    .long_fault(long_fault), .suppress_alarm(suppress_alarm), .diag_index(diag_index),
    .ref_offset(ref_offset), .ctl_word(ctl_word), .nvm_fault(nvm_fault),
    .nvm_write_ok(nvm_write_ok), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_subfunc(tx_subfunc), .tx_dest(tx_dest), .tx_index(tx_index), .tx_byte(tx_byte),
    .tx_last(tx_last), .pulse_drive(pulse_drive), .power_diag_release(power_diag_release),
    .nvm_rewrite(nvm_rewrite), .bus_select_b(bus_select_b), .fault_latched(fault_latched));

  ctl_model u_ctl (.clk_sys(clk_sys), .rstn(rstn), .slow(slow), .tx_valid(tx_valid),
    .tx_subfunc(tx_subfunc), .tx_dest(tx_dest), .tx_index(tx_index), .tx_byte(tx_byte),
    .tx_last(tx_last), .tx_ready(tx_ready));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One-shot events are caught here so a check never has to land on their cycle
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (pulse_drive === 6'h3f) pd_cnt <= pd_cnt + 1;
    if (power_diag_release === 1'b1) rel_seen <= 1'b1;
    if (nvm_rewrite === 1'b1) nvm_seen <= 1'b1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input logic [7:0] sf, input logic [7:0] d0);
    @(posedge clk_sys);
    #1;
    rx_valid   = 1'b1;
    rx_subfunc = sf;
    rx_data0   = d0;
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask

  // Waits until the transmit side has been idle for a while
  task automatic quiet();
    int q;
    q = 0;
    for (int i = 0; i < 400 && q < 12; i++) begin
      @(posedge clk_sys);
      #1;
      q = tx_valid ? 0 : q + 1;
    end
  endtask

  task automatic t_report(input logic [1:0] fl, input logic sl, input logic [1:0] cls,
                          input logic lng, input int ones0);
    int n;
    n = u_ctl.frames;
    flavour = fl;
    slow = sl;
    module_class = cls;
    long_fault = lng;
    fault_cond = 6'h02;
    quiet();
    chk("report count", 16'(n + 1), 16'(u_ctl.frames));
    chk("report dest", {8'h00, ZERO_BYTE}, {8'h00, u_ctl.got_dest});
    chk("report subfunc", {8'h00, SUBF_REPORT_FAULT}, {8'h00, u_ctl.got_sub});
    chk("last flag", 16'(u_ctl.frames), 16'(u_ctl.ends));
    if (fl == FLAVOUR_CHIP) begin
      chk("chip byte0", 16'h0000, {8'h00, u_ctl.got[0]});
      chk("chip byte1", {10'h000, diag_index}, {8'h00, u_ctl.got[1]});
      chk("chip byte2", 16'h0000, {8'h00, u_ctl.got[2]});
      chk("chip length", {13'h0000, CHIP_LAST_BYTE}, {13'h0000, u_ctl.last_idx});
    end else begin
      chk("byte0 ones", 16'(ones0), 16'($countones(u_ctl.got[0])));
      chk("byte1", (fl == FLAVOUR_SCANNER) ? {10'h000, diag_index} : 16'h0000,
          {8'h00, u_ctl.got[1]});
      chk("byte2 ones", 16'h0002, 16'($countones(u_ctl.got[2])));
      chk("bytes 3 4", ref_offset, {u_ctl.got[4], u_ctl.got[3]});
      chk("bytes 5 6", ctl_word, {u_ctl.got[6], u_ctl.got[5]});
      chk("length", {13'h0000, REPORT_LAST_BYTE}, {13'h0000, u_ctl.last_idx});
    end
    fault_cond = 6'h00;
    send(SUBF_CLEAR_CIRCUIT, 8'h01);
    quiet();
    chk("latched after clear", 16'h0000, {10'h000, fault_latched});
    $display("report test done, flavour %0d", fl);
  endtask

  task automatic t_clear();
    int n;
    fault_cond = 6'h18;
    quiet();
    n = u_ctl.frames;
    send(SUBF_CLEAR_CIRCUIT, 8'h06);
    chk("out of range clear", 16'h0018, {10'h000, fault_latched});
    send(SUBF_CLEAR_CIRCUIT, 8'h04);
    quiet();
    chk("persisting re-report", 16'(n + 1), 16'(u_ctl.frames));
    fault_cond = 6'h00;
    send(SUBF_CLEAR_CIRCUIT, 8'h03);
    chk("input circuit clear", 16'h0010, {10'h000, fault_latched});
    send(SUBF_CLEAR_CIRCUIT, 8'h04);
    chk("output circuit clear", 16'h0000, {10'h000, fault_latched});
    $display("clear circuit test done");
  endtask

  task automatic t_clear_all();
    int n;
    fault_cond = 6'h21;
    quiet();
    fault_cond = 6'h01;
    nvm_fault = 1'b1;
    // Failed rewrite must regenerate a report of its own
    nvm_write_ok = 1'b0;
    nvm_seen = 1'b0;
    n = u_ctl.frames;
    send(SUBF_CLEAR_ALL, 8'h00);
    quiet();
    chk("memory rewrite", 16'h0001, {15'h0000, nvm_seen});
    chk("persist after clear all", 16'h0001, {10'h000, fault_latched});
    chk("re-report count", 16'(n + 2), 16'(u_ctl.frames));
    fault_cond = 6'h00;
    nvm_fault = 1'b0;
    nvm_write_ok = 1'b1;
    nvm_seen = 1'b0;
    send(SUBF_CLEAR_ALL, 8'h00);
    quiet();
    chk("no rewrite without fault", 16'h0000, {15'h0000, nvm_seen});
    chk("all cleared", 16'h0000, {10'h000, fault_latched});
    $display("clear all test done");
  endtask

  task automatic t_pulse();
    int n;
    isolated_block = 1'b1;
    rx_source = 8'h5a;
    pd_cnt = 0;
    rel_seen = 1'b0;
    n = u_ctl.frames;
    send(SUBF_PULSE_TEST, 8'h00);
    quiet();
    chk("pulse length", 16'(PULSE_CYCLES) + 16'h0001, 16'(pd_cnt));
    chk("power diag release", 16'h0001, {15'h0000, rel_seen});
    chk("done count", 16'(n + 1), 16'(u_ctl.frames));
    chk("done subfunc", {8'h00, SUBF_PULSE_DONE}, {8'h00, u_ctl.got_sub});
    chk("done dest", 16'h005a, {8'h00, u_ctl.got_dest});
    pulse_override = 1'b1;
    pd_cnt = 0;
    n = u_ctl.frames;
    send(SUBF_PULSE_TEST, 8'h00);
    quiet();
    chk("override pulse", 16'h0000, 16'(pd_cnt));
    chk("override no done", 16'(n), 16'(u_ctl.frames));
    pulse_override = 1'b0;
    isolated_block = 1'b0;
    $display("pulse test done");
  endtask

  task automatic t_switch();
    logic [7:0] codes [0:3];
    int n;
    // 1Eh is a controller memory read request; the node must drop it
    codes = '{8'h0c, 8'h11, 8'h1e, 8'hff};
    // Loss and addition reports after a switch fall to the controllers
    send(SUBF_SWITCH_BUS, BUS_POS_B);
    chk("switch to b", 16'h0001, {15'h0000, bus_select_b});
    send(SUBF_SWITCH_BUS, 8'h02);
    chk("bad position", 16'h0001, {15'h0000, bus_select_b});
    monitor_forced = 1'b1;
    send(SUBF_SWITCH_BUS, BUS_POS_A);
    chk("forced position", 16'h0001, {15'h0000, bus_select_b});
    monitor_forced = 1'b0;
    n = u_ctl.frames;
    pd_cnt = 0;
    for (int i = 0; i < 4; i++) begin
      send(codes[i], 8'h00);
    end
    quiet();
    chk("unknown subfunc", {11'h000, 1'b1, 4'h0}, {u_ctl.frames[10:0], bus_select_b,
        16'(pd_cnt) == 16'h0000 ? 4'h0 : 4'hf} - 16'(n << 5));
    send(SUBF_SWITCH_BUS, BUS_POS_A);
    chk("switch to a", 16'h0000, {15'h0000, bus_select_b});
    $display("bus switch test done");
  endtask

  initial begin
    {rstn, slow, rx_valid, pulse_override, isolated_block, monitor_forced} = 6'h00;
    {long_fault, suppress_alarm, nvm_fault, nvm_write_ok} = 4'h5;
    {rel_seen, nvm_seen} = 2'h0;
    flavour = FLAVOUR_SCANNER;
    module_class = CLASS_DISC_OUT;
    {rx_subfunc, rx_data0, rx_source} = 24'h000000;
    fault_cond = 6'h00;
    diag_index = DIAG_INDEX_MAX;
    ref_offset = 16'hbeef;
    ctl_word = 16'h1234;
    {error_cnt, compares, pd_cnt, cyc} = 128'h0;
    repeat (10) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("reset outputs", 16'h0000, {tx_valid, pulse_drive, bus_select_b, fault_latched,
        nvm_rewrite, power_diag_release});
    t_report(FLAVOUR_SCANNER, 1'b0, CLASS_DISC_OUT, 1'b0, 3);
    t_report(FLAVOUR_SCANNER, 1'b1, CLASS_ANA_IN, 1'b1, 5);
    t_report(FLAVOUR_IFACE, 1'b0, CLASS_DISC_IN, 1'b0, 4);
    t_report(FLAVOUR_CHIP, 1'b1, CLASS_ANA_OUT, 1'b0, 0);
    flavour = FLAVOUR_SCANNER;
    t_clear();
    t_clear_all();
    t_pulse();
    t_switch();
    conclude();
  end
endmodule
`default_nettype wire
